// file: hw/asfc_defs.svh
// Constants and functional notes for the async serial flow control block
`ifndef ASFC_DEFS_SVH
`define ASFC_DEFS_SVH
// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define ASFC_A_CFG 4'h0
`define ASFC_A_STAT 4'h1
`define ASFC_A_TXD 4'h2
`define ASFC_A_RXD 4'h3
`define ASFC_A_XON 4'h4
`define ASFC_A_XOFF 4'h5
`define ASFC_A_XON_COMPARE_MASK 4'h6
`define ASFC_A_XOFF_COMPARE_MASK 4'h7
`define ASFC_A_IMM 4'h8
`define ASFC_A_TERM 4'h9
`define ASFC_A_TOUT 4'hA
`define ASFC_A_CMD 4'hB
// ----------------------------------------
// Configuration bit positions
// ----------------------------------------
`define ASFC_C_RXEN 0
`define ASFC_C_CHL 2:1
`define ASFC_C_STOP2 3
`define ASFC_C_PARE 4
`define ASFC_C_PAR 6:5
`define ASFC_C_BRK 7
`define ASFC_C_DXS 8
`define ASFC_C_INBAND_FLOW_ENABLE 9
`define ASFC_C_IGNORE_CLEAR_TO_SEND 10
`define ASFC_C_AUTO_RECEIVE_FLOW 11
`define ASFC_C_RTS 12
`define ASFC_C_TERMINATION_DETECT_ENABLE 13
`define ASFC_C_RX_DATA_FORMAT 14
`define ASFC_C_DPS 15
`define ASFC_C_TOEN 16
`define ASFC_C_RX_FILL_THRESHOLD 21:17
`define ASFC_C_DIV 31:24
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define ASFC_S_FCS 0
`define ASFC_S_TEC 1
`define ASFC_S_ALL_SENT_FLAG 2
`define ASFC_S_XPR 3
`define ASFC_S_FERR 4
`define ASFC_S_PERR 5
`define ASFC_S_BRK 6
`define ASFC_S_BREAK_END_FLAG 7
`define ASFC_S_XONR 8
`define ASFC_S_XOFFR 9
`define ASFC_S_TOUT 10
`define ASFC_S_TCD 11
`define ASFC_S_RFULL 12
`define ASFC_S_RLEV 13
`define ASFC_S_RNE 14
`define ASFC_S_STICKY 16'h2FFC
// ----------------------------------------
// Sizes, counts and reset values
// ----------------------------------------
`define ASFC_DEPTH 32
`define ASFC_PW 5
`define ASFC_RTS_HI 6'd28
`define ASFC_OVS 4'hF
`define ASFC_MID 4'h7
`define ASFC_V1 4'h6
`define ASFC_V3 4'h8
`define ASFC_CFG_RST 32'h0000_0000
`define ASFC_DIV_RST 8'h01
`define ASFC_TOUT_RST 16'hFFFF
`endif

// file: hw/asfc_pkg.sv
// Types for the async serial flow control block
package asfc_pkg;
    // Transmit framing phases, Gray along start-data-parity-stop
    typedef enum logic [2:0] {
        ASFC_TX_IDLE = 3'h0,
        ASFC_TX_START = 3'h1,
        ASFC_TX_DATA = 3'h3,
        ASFC_TX_PAR = 3'h2,
        ASFC_TX_STOP = 3'h6
    } asfc_txst_t;
    // Receive framing phases
    typedef enum logic [2:0] {
        ASFC_RX_IDLE = 3'h0,
        ASFC_RX_START = 3'h1,
        ASFC_RX_DATA = 3'h3,
        ASFC_RX_PAR = 3'h2,
        ASFC_RX_STOP = 3'h6,
        ASFC_RX_BRK = 3'h7
    } asfc_rxst_t;
    // One receive FIFO entry: data plus error status
    typedef struct packed {
        logic perr;
        logic ferr;
        logic [7:0] data;
    } asfc_rxent_t;
endpackage

// file: hw/async_serial_flow_control.sv
// Async serial channel with XON/XOFF, break, immediate char and RTS/CTS
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "asfc_defs.svh"
module async_serial_flow_control
    import asfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rxData,
    output logic txData,
    input wire logic ctsIn_n,
    output logic rtsOut_n,
    output logic txDmaReq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] cfg_reg, cfg_next; // Channel configuration
    logic [15:0] stat_reg, stat_next; // Sticky and live status
    logic [7:0] xon_reg, xon_next, xoff_reg, xoff_next;
    logic [7:0] xon_compare_mask_reg, xon_compare_mask_next, xoff_compare_mask_reg, xoff_compare_mask_next;
    logic [7:0] imm_reg, imm_next, term_reg, term_next;
    logic [15:0] tout_reg, tout_next; // Idle length in bit times
    logic [31:0] rdat_reg, rdat_next;
    logic ack_reg, ack_next; // One wait state per access
    // Transmit FIFO
    logic [7:0] txMem [`ASFC_DEPTH];
    logic [`ASFC_PW:0] txWp_reg, txWp_next, txRp_reg, txRp_next;
    // Receive shadow and host FIFOs
    asfc_rxent_t shMem [`ASFC_DEPTH];
    asfc_rxent_t rxMem [`ASFC_DEPTH];
    logic [`ASFC_PW:0] shWp_reg, shWp_next, shRp_reg, shRp_next;
    logic [`ASFC_PW:0] rxWp_reg, rxWp_next, rxRp_reg, rxRp_next;
    // Transmitter state
    asfc_txst_t txSt_reg, txSt_next;
    logic [7:0] txSh_reg, txSh_next, baud_reg, baud_next;
    logic [3:0] txOv_reg, txOv_next;
    logic [2:0] txBit_reg, txBit_next;
    logic txStop2_reg, txStop2_next, txPar_reg, txPar_next;
    logic txLine_reg, txLine_next, txRun_reg, txRun_next;
    logic isImm_reg, isImm_next, xoff_st_reg, xoff_st_next;
    logic flonD_reg, flonD_next, rts_reg, rts_next;
    // Receiver state
    asfc_rxst_t rxSt_reg, rxSt_next;
    logic [3:0] rxOv_reg, rxOv_next;
    logic [2:0] rxBit_reg, rxBit_next, vote_reg, vote_next;
    logic [7:0] rxSh_reg, rxSh_next;
    logic rxPar_reg, rxPar_next, rxZero_reg, rxZero_next;
    logic [15:0] idle_reg, idle_next;
    logic idleArm_reg, idleArm_next;

    // Helpers
    logic tick, wr, rd, rxSamp, rxWe, shWe, mv, popRx, pushTx, bitEnd, parCalc;
    logic [2:0] lastBit;
    asfc_rxent_t rxEnt;
    logic [`ASFC_PW:0] shLev, rxLev, txLev;

    // Masked compare within configured length
    function automatic logic flowMatch(input logic [7:0] c, input logic [7:0] v,
                                       input logic [7:0] m, input logic [2:0] lb);
        logic [7:0] lm;
        lm = 8'hFF >> (3'h7 - lb);
        return ((c ^ v) & lm & ~m) == 8'h00;
    endfunction
    // Parity bit from mode: 0 even, 1 odd, 2 mark, 3 space
    function automatic logic parOf(input logic [7:0] c, input logic [1:0] md, input logic [2:0] lb);
        logic x;
        x = ^(c & (8'hFF >> (3'h7 - lb)));
        return (md == 2'h0) ? x : (md == 2'h1) ? ~x : (md == 2'h2);
    endfunction

    assign lastBit = {1'b1, cfg_reg[`ASFC_C_CHL]}; // Length 5..8 -> last index 4..7
    assign tick = (baud_reg == 8'h00);
    assign wr = avs_write & ack_reg; // Write lands at the edge after the wait ends, where waitrequest is seen low
    assign rd = avs_read & ~ack_reg;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rdat_reg;
    assign txData = txLine_reg;
    assign rtsOut_n = rts_reg;
    assign shLev = shWp_reg - shRp_reg;
    assign rxLev = rxWp_reg - rxRp_reg;
    assign txLev = txWp_reg - txRp_reg;
    assign mv = (shLev != '0) && (rxLev != `ASFC_DEPTH);
    assign popRx = rd && (avs_address[3:0] == `ASFC_A_RXD) && (rxLev != '0);
    assign pushTx = wr && (avs_address[3:0] == `ASFC_A_TXD) && (txLev != `ASFC_DEPTH);
    assign txDmaReq = txRun_reg && (txLev != `ASFC_DEPTH);
    assign rxSamp = tick && (rxOv_reg == `ASFC_MID);
    assign bitEnd = tick && (txOv_reg == `ASFC_OVS);
    assign parCalc = parOf(rxSh_reg, cfg_reg[`ASFC_C_PAR], lastBit);

    // ----------------------------------------
    // FIFO memories
    // ----------------------------------------
    // Arrays written only; pointers handled in the state group
    always_ff @(posedge core_clk) begin
        if (pushTx) begin
            txMem[txWp_reg[`ASFC_PW-1:0]] <= avs_writedata[7:0];
        end
        if (shWe) begin
            shMem[shWp_reg[`ASFC_PW-1:0]] <= rxEnt;
        end
        if (mv) begin
            rxMem[rxWp_reg[`ASFC_PW-1:0]] <= shMem[shRp_reg[`ASFC_PW-1:0]];
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic stopBit, cts, isXon, isXoff, good, store, canGo;
        asfc_rxent_t hd;
        cfg_next = cfg_reg; stat_next = stat_reg; xon_next = xon_reg; xoff_next = xoff_reg;
        xon_compare_mask_next = xon_compare_mask_reg; xoff_compare_mask_next = xoff_compare_mask_reg; imm_next = imm_reg; term_next = term_reg;
        tout_next = tout_reg; rdat_next = rdat_reg; ack_next = avs_read | avs_write ? ~ack_reg : 1'b0;
        txWp_next = txWp_reg + {{`ASFC_PW{1'b0}}, pushTx};
        txRp_next = txRp_reg; shWp_next = shWp_reg; shRp_next = shRp_reg + {{`ASFC_PW{1'b0}}, mv};
        rxWp_next = rxWp_reg + {{`ASFC_PW{1'b0}}, mv}; rxRp_next = rxRp_reg + {{`ASFC_PW{1'b0}}, popRx};
        txSt_next = txSt_reg; txSh_next = txSh_reg; txOv_next = txOv_reg + {3'h0, tick};
        txBit_next = txBit_reg; txStop2_next = txStop2_reg; txPar_next = txPar_reg;
        txLine_next = txLine_reg; txRun_next = txRun_reg; isImm_next = isImm_reg;
        xoff_st_next = xoff_st_reg; flonD_next = cfg_reg[`ASFC_C_INBAND_FLOW_ENABLE]; rts_next = rts_reg;
        baud_next = tick ? cfg_reg[`ASFC_C_DIV] - 8'h01 : baud_reg - 8'h01;
        rxSt_next = rxSt_reg; rxOv_next = rxOv_reg + {3'h0, tick}; rxBit_next = rxBit_reg;
        vote_next = vote_reg; rxSh_next = rxSh_reg; rxPar_next = rxPar_reg; rxZero_next = rxZero_reg;
        idle_next = idle_reg; idleArm_next = idleArm_reg;
        shWe = 1'b0; rxEnt = '0; rxWe = 1'b0;
        stopBit = 1'b0; isXon = 1'b0; isXoff = 1'b0; good = 1'b0; store = 1'b0;
        hd = rxMem[rxRp_reg[`ASFC_PW-1:0]];
        cts = ~ctsIn_n | cfg_reg[`ASFC_C_IGNORE_CLEAR_TO_SEND];
        canGo = cts && !(cfg_reg[`ASFC_C_INBAND_FLOW_ENABLE] && xoff_st_reg);
        // Register writes
        if (wr) begin
            unique case (avs_address[3:0])
                `ASFC_A_CFG: cfg_next = avs_writedata;
                `ASFC_A_STAT: stat_next = stat_reg & ~(avs_writedata[15:0] & `ASFC_S_STICKY);
                `ASFC_A_XON: xon_next = avs_writedata[7:0];
                `ASFC_A_XOFF: xoff_next = avs_writedata[7:0];
                `ASFC_A_XON_COMPARE_MASK: xon_compare_mask_next = avs_writedata[7:0];
                `ASFC_A_XOFF_COMPARE_MASK: xoff_compare_mask_next = avs_writedata[7:0];
                `ASFC_A_IMM: begin
                    if (!stat_reg[`ASFC_S_TEC]) begin
                        imm_next = avs_writedata[7:0];
                        stat_next[`ASFC_S_TEC] = 1'b1;
                    end
                end
                `ASFC_A_TERM: term_next = avs_writedata[7:0];
                `ASFC_A_TOUT: tout_next = avs_writedata[15:0];
                `ASFC_A_CMD: begin
                    if (avs_writedata[0]) begin
                        txRun_next = 1'b1;
                        stat_next[`ASFC_S_ALL_SENT_FLAG] = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Register reads
        if (rd) begin
            unique case (avs_address[3:0])
                `ASFC_A_CFG: rdat_next = cfg_reg;
                `ASFC_A_STAT: rdat_next = {16'h0000, stat_reg};
                `ASFC_A_RXD: rdat_next = {22'h0, hd.perr, hd.ferr, hd.data};
                `ASFC_A_XON: rdat_next = {24'h0, xon_reg};
                `ASFC_A_XOFF: rdat_next = {24'h0, xoff_reg};
                `ASFC_A_XON_COMPARE_MASK: rdat_next = {24'h0, xon_compare_mask_reg};
                `ASFC_A_XOFF_COMPARE_MASK: rdat_next = {24'h0, xoff_compare_mask_reg};
                `ASFC_A_IMM: rdat_next = {24'h0, imm_reg};
                `ASFC_A_TERM: rdat_next = {24'h0, term_reg};
                `ASFC_A_TOUT: rdat_next = {16'h0, tout_reg};
                default: rdat_next = 32'h0;
            endcase
        end
        // Flow enable edges force XON state
        if (cfg_reg[`ASFC_C_INBAND_FLOW_ENABLE] != flonD_reg) begin
            xoff_st_next = 1'b0;
        end
        // Transmitter
        unique case (txSt_reg)
            ASFC_TX_IDLE: begin
                txLine_next = ~cfg_reg[`ASFC_C_BRK];
                if (tick && cts && stat_reg[`ASFC_S_TEC]) begin
                    txSh_next = imm_reg; isImm_next = 1'b1; txSt_next = ASFC_TX_START;
                end else if (tick && txRun_reg && canGo && txLev != '0) begin
                    txSh_next = txMem[txRp_reg[`ASFC_PW-1:0]]; isImm_next = 1'b0;
                    txRp_next = txRp_reg + 1'b1; txSt_next = ASFC_TX_START;
                end else if (txRun_reg && txLev == '0 && !stat_reg[`ASFC_S_TEC]) begin
                    txRun_next = 1'b0; stat_next[`ASFC_S_ALL_SENT_FLAG] = 1'b1;
                end
                txOv_next = 4'h0; txBit_next = 3'h0;
            end
            ASFC_TX_START: begin
                txLine_next = 1'b0;
                txPar_next = parOf(txSh_reg, cfg_reg[`ASFC_C_PAR], lastBit);
                if (bitEnd) txSt_next = ASFC_TX_DATA;
            end
            ASFC_TX_DATA: begin
                txLine_next = txSh_reg[txBit_reg] & ~cfg_reg[`ASFC_C_BRK];
                if (bitEnd) begin
                    txBit_next = txBit_reg + 3'h1;
                    if (txBit_reg == lastBit) begin
                        txSt_next = cfg_reg[`ASFC_C_PARE] ? ASFC_TX_PAR : ASFC_TX_STOP;
                        txStop2_next = cfg_reg[`ASFC_C_STOP2];
                    end
                end
            end
            ASFC_TX_PAR: begin
                txLine_next = txPar_reg & ~cfg_reg[`ASFC_C_BRK];
                if (bitEnd) txSt_next = ASFC_TX_STOP;
            end
            ASFC_TX_STOP: begin
                txLine_next = ~cfg_reg[`ASFC_C_BRK];
                if (bitEnd) begin
                    txStop2_next = 1'b0;
                    if (!txStop2_reg) begin
                        txSt_next = ASFC_TX_IDLE;
                        if (isImm_reg) stat_next[`ASFC_S_TEC] = 1'b0;
                        if (!isImm_reg) stat_next[`ASFC_S_XPR] = 1'b1;
                    end
                end
            end
            default: txSt_next = ASFC_TX_IDLE;
        endcase
        if (txSt_reg != ASFC_TX_IDLE && cfg_reg[`ASFC_C_BRK]) txLine_next = 1'b0;
        // Receiver with 16x oversampling
        if (tick && rxOv_reg >= `ASFC_V1 && rxOv_reg <= `ASFC_V3) begin
            vote_next = {vote_reg[1:0], rxData};
        end
        stopBit = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2]) | (vote_reg[0] & vote_reg[2]);
        unique case (rxSt_reg)
            ASFC_RX_IDLE: begin
                rxBit_next = 3'h0; rxZero_next = 1'b1; // Oversample count runs on to time the idle line
                if (cfg_reg[`ASFC_C_RXEN] && !rxData) rxSt_next = ASFC_RX_START;
            end
            ASFC_RX_START: begin
                if (tick && rxOv_reg == `ASFC_V3 + 4'h1) begin
                    if (stopBit) rxSt_next = ASFC_RX_IDLE;
                end
                if (tick && rxOv_reg == `ASFC_OVS) rxSt_next = ASFC_RX_DATA;
            end
            ASFC_RX_DATA: begin
                if (tick && rxOv_reg == `ASFC_OVS) begin
                    rxSh_next[rxBit_reg] = stopBit;
                    rxZero_next = rxZero_reg & ~stopBit;
                    rxBit_next = rxBit_reg + 3'h1;
                    if (rxBit_reg == lastBit) rxSt_next = cfg_reg[`ASFC_C_PARE] ? ASFC_RX_PAR : ASFC_RX_STOP;
                    if (rxBit_reg == 3'h0) rxSh_next[7:1] = 7'h00;
                end
            end
            ASFC_RX_PAR: begin
                if (tick && rxOv_reg == `ASFC_OVS) begin
                    rxPar_next = stopBit; rxZero_next = rxZero_reg & ~stopBit; rxSt_next = ASFC_RX_STOP;
                end
            end
            ASFC_RX_STOP: begin
                if (tick && rxOv_reg == `ASFC_OVS) begin
                    rxSt_next = ASFC_RX_IDLE; idle_next = 16'h0; idleArm_next = 1'b1;
                    good = stopBit && (!cfg_reg[`ASFC_C_PARE] || rxPar_reg == parCalc);
                    isXon = good && flowMatch(rxSh_reg, xon_reg, xon_compare_mask_reg, lastBit);
                    isXoff = good && flowMatch(rxSh_reg, xoff_reg, xoff_compare_mask_reg, lastBit);
                    if (rxZero_reg && !stopBit) begin
                        stat_next[`ASFC_S_BRK] = 1'b1; rxSt_next = ASFC_RX_BRK;
                    end else begin
                        store = !((isXon || isXoff) && cfg_reg[`ASFC_C_DXS]);
                        if (isXon) stat_next[`ASFC_S_XONR] = 1'b1;
                        if (isXoff) stat_next[`ASFC_S_XOFFR] = 1'b1;
                        if (cfg_reg[`ASFC_C_INBAND_FLOW_ENABLE] && isXoff) xoff_st_next = 1'b1;
                        if (cfg_reg[`ASFC_C_INBAND_FLOW_ENABLE] && isXon) xoff_st_next = 1'b0;
                        if (!stopBit) stat_next[`ASFC_S_FERR] = 1'b1;
                        if (cfg_reg[`ASFC_C_PARE] && rxPar_reg != parCalc) stat_next[`ASFC_S_PERR] = 1'b1;
                        if (cfg_reg[`ASFC_C_TERMINATION_DETECT_ENABLE] && rxSh_reg == term_reg) stat_next[`ASFC_S_TCD] = 1'b1;
                    end
                end
            end
            ASFC_RX_BRK: begin
                if (rxData) begin
                    stat_next[`ASFC_S_BREAK_END_FLAG] = 1'b1; rxSt_next = ASFC_RX_IDLE;
                end
            end
            default: rxSt_next = ASFC_RX_IDLE;
        endcase
        if (rxSt_reg == ASFC_RX_IDLE && !rxData && cfg_reg[`ASFC_C_RXEN]) rxOv_next = 4'h0;
        // Store entry, with or without parity and error status
        rxEnt.data = rxSh_reg;
        if (!cfg_reg[`ASFC_C_DPS] && cfg_reg[`ASFC_C_PARE] && lastBit != 3'h7) rxEnt.data[lastBit + 3'h1] = rxPar_reg;
        rxEnt.ferr = cfg_reg[`ASFC_C_RX_DATA_FORMAT] & ~stopBit;
        rxEnt.perr = cfg_reg[`ASFC_C_RX_DATA_FORMAT] & cfg_reg[`ASFC_C_PARE] & (rxPar_reg != parCalc);
        shWe = store && (shLev != `ASFC_DEPTH);
        shWp_next = shWp_reg + {{`ASFC_PW{1'b0}}, shWe};
        // Idle time-out in bit times
        if (tick && rxOv_reg == `ASFC_OVS && idleArm_reg && rxSt_reg == ASFC_RX_IDLE) begin
            idle_next = idle_reg + 16'h1;
            if (idle_reg == tout_reg && cfg_reg[`ASFC_C_TOEN]) begin
                stat_next[`ASFC_S_TOUT] = 1'b1; idleArm_next = 1'b0;
            end
        end
        // Automatic request-to-send
        if (cfg_reg[`ASFC_C_AUTO_RECEIVE_FLOW] && !cfg_reg[`ASFC_C_RTS]) begin
            if ({1'b0, shLev} >= `ASFC_RTS_HI) rts_next = 1'b1;
            else if (shLev == '0) rts_next = 1'b0;
        end else begin
            rts_next = cfg_reg[`ASFC_C_RTS];
        end
        // Live status bits
        stat_next[`ASFC_S_FCS] = xoff_st_next;
        stat_next[`ASFC_S_RNE] = (rxLev != '0);
        stat_next[`ASFC_S_RLEV] = (rxLev >= {1'b0, cfg_reg[`ASFC_C_RX_FILL_THRESHOLD]});
        stat_next[`ASFC_S_RFULL] = (rxLev == `ASFC_DEPTH);
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    // Synchronous reset, masks cleared to zero
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cfg_reg <= `ASFC_CFG_RST; stat_reg <= 16'h0; xon_reg <= 8'h00; xoff_reg <= 8'h00;
            xon_compare_mask_reg <= 8'h00; xoff_compare_mask_reg <= 8'h00; imm_reg <= 8'h00; term_reg <= 8'h00;
            tout_reg <= `ASFC_TOUT_RST; rdat_reg <= 32'h0; ack_reg <= 1'b0;
            txWp_reg <= '0; txRp_reg <= '0; shWp_reg <= '0; shRp_reg <= '0; rxWp_reg <= '0; rxRp_reg <= '0;
            txSt_reg <= ASFC_TX_IDLE; txSh_reg <= 8'h00; baud_reg <= 8'h00; txOv_reg <= 4'h0;
            txBit_reg <= 3'h0; txStop2_reg <= 1'b0; txPar_reg <= 1'b0; txLine_reg <= 1'b1;
            txRun_reg <= 1'b0; isImm_reg <= 1'b0; xoff_st_reg <= 1'b0; flonD_reg <= 1'b0; rts_reg <= 1'b0;
            rxSt_reg <= ASFC_RX_IDLE; rxOv_reg <= 4'h0; rxBit_reg <= 3'h0; vote_reg <= 3'h7;
            rxSh_reg <= 8'h00; rxPar_reg <= 1'b0; rxZero_reg <= 1'b0; idle_reg <= 16'h0; idleArm_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next; stat_reg <= stat_next; xon_reg <= xon_next; xoff_reg <= xoff_next;
            xon_compare_mask_reg <= xon_compare_mask_next; xoff_compare_mask_reg <= xoff_compare_mask_next; imm_reg <= imm_next; term_reg <= term_next;
            tout_reg <= tout_next; rdat_reg <= rdat_next; ack_reg <= ack_next;
            txWp_reg <= txWp_next; txRp_reg <= txRp_next; shWp_reg <= shWp_next; shRp_reg <= shRp_next;
            rxWp_reg <= rxWp_next; rxRp_reg <= rxRp_next;
            txSt_reg <= txSt_next; txSh_reg <= txSh_next; baud_reg <= baud_next; txOv_reg <= txOv_next;
            txBit_reg <= txBit_next; txStop2_reg <= txStop2_next; txPar_reg <= txPar_next;
            txLine_reg <= txLine_next; txRun_reg <= txRun_next; isImm_reg <= isImm_next;
            xoff_st_reg <= xoff_st_next; flonD_reg <= flonD_next; rts_reg <= rts_next;
            rxSt_reg <= rxSt_next; rxOv_reg <= rxOv_next; rxBit_reg <= rxBit_next; vote_reg <= vote_next;
            rxSh_reg <= rxSh_next; rxPar_reg <= rxPar_next; rxZero_reg <= rxZero_next;
            idle_reg <= idle_next; idleArm_reg <= idleArm_next;
        end
    end
endmodule
`default_nettype wire

// file: tb/asfc_properties.sv
// Port checker for the serial flow block
`timescale 1ns/1ps
`default_nettype none
module asfc_properties (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic txData,
    input wire logic rtsOut_n,
    input wire logic txDmaReq
);
    logic [31:0] cfgReg; // Configuration word as last accepted
    logic xfReg; // A transmit command has been accepted
    wire logic acc = avs_write && !avs_waitrequest;
    // Shadow of the host writes, so rules can be tied to the settings
    always_ff @(posedge core_clk) begin
        if (!rst_b) {cfgReg, xfReg} <= '0;
        else if (acc && avs_address[3:0] == 4'h0) cfgReg <= avs_writedata;
        else if (acc && avs_address[3:0] == 4'hB) xfReg <= xfReg | avs_writedata[0];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_ack; avs_waitrequest ##1 !avs_waitrequest; endsequence
    sequence s_low; !txData [*8]; endsequence
    property p_wreq; $rose(avs_read || avs_write) |-> s_ack; endproperty
    a_wreq: assert property (p_wreq) else $error("bus answer late");
    property p_start; $fell(txData) |-> s_low; endproperty
    a_start: assert property (p_start) else $error("short low bit");
    property p_high; $rose(txData) |-> txData [*8]; endproperty
    a_high: assert property (p_high) else $error("short high bit");
    property p_brk; $rose(cfgReg[7]) |-> ##[1:260] !txData; endproperty
    a_brk: assert property (p_brk) else $error("break not driven");
    property p_brkhold; cfgReg[7] && !txData |=> !txData; endproperty
    a_brkhold: assert property (p_brkhold) else $error("break not held");
    property p_brkrel; $fell(cfgReg[7]) |-> ##[0:260] txData; endproperty
    a_brkrel: assert property (p_brkrel) else $error("break not released");
    property p_rts; $rose(rtsOut_n) |-> cfgReg[11] || cfgReg[12]; endproperty
    a_rts: assert property (p_rts) else $error("rts raised without cause");
    property p_dma; !xfReg |-> !txDmaReq; endproperty
    a_dma: assert property (p_dma) else $error("data request before command");
endmodule
bind async_serial_flow_control asfc_properties i_props (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .txData(txData), .rtsOut_n(rtsOut_n), .txDmaReq(txDmaReq));
`default_nettype wire

// file: tb/asfc_remote.sv
// Remote station on the serial line
`timescale 1ns/1ps
`default_nettype none
module asfc_remote (
    input wire logic core_clk,
    input wire logic lineIn,
    output logic lineOut = 1'b1,
    output logic gotStb = 1'b0,
    output logic [7:0] gotByte
);
    logic [9:0] rx, tx; // Frame being decoded and being sent
    // Start, eight data bits LSB first, one stop; the line idles high
    task automatic send(input logic [7:0] d);
        tx = {1'b1, d, 1'b0};
        for (int i = 0; i < 160; i++) @(posedge core_clk) lineOut <= tx[i / 16];
    endtask
    // Sample mid-bit; a low stop bit (break) yields no character
    always begin
        @(negedge lineIn);
        for (int i = 0; i < 10; i++) begin
            repeat (i ? 16 : 8) @(posedge core_clk);
            rx[i] = lineIn;
        end
        gotByte = rx[8:1];
        gotStb <= rx[9] & !rx[0];
        @(posedge core_clk) gotStb <= 1'b0;
    end
endmodule
`default_nettype wire

// file: tb/async_serial_flow_control_bench.sv
// Self-checking bench for the serial flow block
`timescale 1ns/1ps
`default_nettype none
module async_serial_flow_control_bench;
    localparam logic [31:0] CFG = 32'h0100_0207; // Rx on, 8 bits, in-band flow, divider 1
    logic core_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ctsIn_n = 1'b0;
    logic avs_waitrequest, rxData, txData, rtsOut_n, txDmaReq, gotStb;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [7:0] gotByte, e, r;
    logic [7:0] expQ[$]; // Bytes the remote end should see, oldest first
    int failures = 0, checked = 0, cyc = 0;
    async_serial_flow_control i_dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxData(rxData), .txData(txData), .ctsIn_n(ctsIn_n),
        .rtsOut_n(rtsOut_n), .txDmaReq(txDmaReq));
    asfc_remote i_rem (.core_clk(core_clk), .lineIn(txData), .lineOut(rxData), .gotStb(gotStb), .gotByte(gotByte));
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin failures++; $display("BAD %s expected %h seen %h", n, x, s); end
    endtask
    task automatic close_out;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One Avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk) {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
    endtask
    task automatic idle(input int n); repeat (n) @(posedge core_clk); endtask
    task automatic txq(input logic [7:0] d); bus(1, 6'h02, d); bus(1, 6'h0B, 1); endtask
    task automatic drain;
        for (int i = 0; i < 3000 && expQ.size(); i++) @(posedge core_clk);
        chk("txPending", expQ.size(), 0);
    endtask
    // Each decoded character is matched against the oldest expectation
    always @(posedge gotStb) begin
        e = expQ.size() ? expQ.pop_front() : ~gotByte;
        chk("txByte", gotByte, e);
    end
    always @(posedge core_clk) if (++cyc == 40000) begin failures++; close_out; end
    initial begin
        r = 8'($urandom(32'hF456));
        idle(20);
        rst_b <= 1'b1;
        chk("txIdle", txData, 1'b1);
        chk("rtsIdle", rtsOut_n, 1'b0);
        bus(0, 6'h06, 0); chk("xonMask", rd[7:0], 8'h00);
        bus(0, 6'h01, 0); chk("flowRst", rd[0], 1'b0);
        bus(1, 6'h00, CFG); bus(1, 6'h04, 8'h11); bus(1, 6'h05, 8'h13); bus(1, 6'h07, 8'h04);
        expQ.push_back(r); txq(r); drain; $display("framing test done");
        i_rem.send(8'h17); idle(40); // Matches the stop character only through its mask
        bus(0, 6'h01, 0); chk("flowXoff", rd[0], 1'b1);
        chk("xoffSeen", rd[9], 1'b1);
        r = 8'($urandom); txq(r); idle(400);
        expQ.push_back(8'hA5); expQ.push_back(r); bus(1, 6'h08, 8'hA5);
        bus(0, 6'h01, 0); chk("immPend", rd[1], 1'b1);
        idle(300); i_rem.send(8'h11); drain;
        bus(0, 6'h03, 0); chk("rxFlowChar", rd[7:0], 8'h17);
        $display("flow control test done");
        ctsIn_n <= 1'b1; r = 8'($urandom); txq(r); idle(400);
        chk("dmaReq", txDmaReq, 1'b1);
        expQ.push_back(r); ctsIn_n <= 1'b0; drain; $display("clear-to-send test done");
        bus(1, 6'h00, CFG | 32'h80); idle(300); chk("brkLow", txData, 1'b0);
        bus(1, 6'h00, CFG); idle(300); chk("brkEnd", txData, 1'b1);
        chk("dmaIdle", txDmaReq, 1'b0);
        bus(0, 6'h01, 0); chk("allSent", rd[2], 1'b1);
        $display("break test done");
        close_out;
    end
endmodule
`default_nettype wire
